// ### rtl/ugc_pkg.sv
package ugc_pkg;
    // usb global control register, its place in the core's special-function space
    localparam logic [7:0] UGC_CTRL_SFR_ADDR = 8'hBC;
    localparam logic [7:0] UGC_CTRL_RESET = 8'h00;

    // bit positions inside the global control register
    localparam int UGC_BIT_CONTROLLER_ENABLE = 7;
    localparam int UGC_BIT_SUSPEND_CLOCK_GATE = 6;
    localparam int UGC_BIT_REMOTE_WAKE_REQUEST = 5;
    localparam int UGC_BIT_DETACH = 4;
    localparam int UGC_BIT_UPSTREAM_RESUME_ACTIVE = 3;
    localparam int UGC_BIT_REMOTE_WAKE_ALLOWED = 2;
    localparam int UGC_BIT_DEVICE_CONFIGURED_FLAG = 1;
    localparam int UGC_BIT_FUNCTION_ADDRESS_VALID = 0;

    // timing
    localparam int UGC_CLK_PERIOD_NS = 20;
    localparam int UGC_SUSPEND_MIN_MS = 5;
    localparam int UGC_SE0_RESET_MIN_NS = 2700;
    localparam int UGC_SUSPEND_MIN_CYCLES =
        (UGC_SUSPEND_MIN_MS * 1000000 + UGC_CLK_PERIOD_NS - 1) / UGC_CLK_PERIOD_NS;
    localparam int UGC_SE0_RESET_MIN_CYCLES =
        (UGC_SE0_RESET_MIN_NS + UGC_CLK_PERIOD_NS - 1) / UGC_CLK_PERIOD_NS;

    // avalon-mm map of the controller end (byte addresses)
    localparam int UGC_AVS_ADDR_W = 4;
    localparam logic [3:0] UGC_AVS_CTRL_OFFSET = 4'h0;
    localparam logic [3:0] UGC_AVS_INFO_OFFSET = 4'h4;
    localparam logic [31:0] UGC_AVS_READ_ZERO = 32'h00000000;

    typedef enum logic {UGC_BUS_IDLE, UGC_BUS_ACK} ugc_bus_state_type;
endpackage

// ### rtl/ugc_link_if.sv
`timescale 1ns/100ps
interface ugc_link_if;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] ctrl_reg;

    modport dev (input wr_stb, input wr_addr, input wr_data, output ctrl_reg);
    modport ctl (output wr_stb, output wr_addr, output wr_data, input ctrl_reg);
endinterface

// ### rtl/ugc_hold_timer.sv
`timescale 1ns/100ps
module ugc_hold_timer
    import ugc_pkg::*;
#(
    parameter int CYCLES = UGC_SE0_RESET_MIN_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_run,
    output logic o_done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;

    // done rises after i_run has held CYCLES edges, drops as soon as i_run drops
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_done = done_ff;
        if (!i_run) begin
            nxt_cnt = '0;
            nxt_done = 1'b0;
        end else if (cnt_ff == LAST) begin
            nxt_done = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign o_done = done_ff;
endmodule

// ### rtl/ugc_device.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// - enable bit runs controller; clear stops clocks, transceiver, bus timers and any resume
// - wake request resumes only if allowed, clocked, suspended
// - firmware alone clears the wake request bit
// - detach bit floats pull-up supply, else drives high
// - resume flag set on start, cleared when sent
// - firmware sets wake-allowed only if host enabled it
// - firmware sets/clears configured per set-configuration value
// - configured cleared on hardware reset or bus reset
// - firmware sets address valid after set-address status
// - address valid cleared on resets; clear means address zero
// - firmware clears suspend flag before requesting wake
module ugc_device
    import ugc_pkg::*;
#(
    parameter int SUSPEND_CYCLES = UGC_SUSPEND_MIN_CYCLES,
    parameter int SE0_CYCLES = UGC_SE0_RESET_MIN_CYCLES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    ugc_link_if.dev link,
    input wire logic I_BUS_SE0,
    input wire logic I_BUS_IDLE,
    input wire logic I_RESUME_SENT,
    output logic O_CONTROLLER_ENABLE,
    output logic O_XCVR_ENABLE,
    output logic O_CLOCK_RUN,
    output logic O_VREF_OUT,
    output logic O_VREF_OE,
    output logic O_RESUME_DRIVE,
    output logic O_CONFIGURED,
    output logic O_DEFAULT_ADDR,
    output logic O_BUS_RESET
);
    logic controller_enable_ff;
    logic suspend_clock_gate_ff;
    logic remote_wake_request_ff;
    logic detach_ff;
    logic upstream_resume_active_ff;
    logic remote_wake_allowed_ff;
    logic device_configured_flag_ff;
    logic function_address_valid_ff;
    logic wake_fired_ff;
    logic clock_run_ff;
    logic vref_oe_ff;
    logic vref_out_ff;
    logic default_addr_ff;
    logic bus_reset_ff;
    logic [7:0] ctrl_reg_ff;

    logic nxt_controller_enable;
    logic nxt_suspend_clock_gate;
    logic nxt_remote_wake_request;
    logic nxt_detach;
    logic nxt_upstream_resume_active;
    logic nxt_remote_wake_allowed;
    logic nxt_device_configured_flag;
    logic nxt_function_address_valid;
    logic nxt_wake_fired;
    logic nxt_clock_run;
    logic nxt_vref_oe;
    logic nxt_default_addr;
    logic nxt_bus_reset;
    logic [7:0] nxt_ctrl_reg;

    logic reg_write;
    logic clocks_running;
    logic se0_long;
    logic suspended_long;
    logic wake_start;

    assign reg_write = link.wr_stb && (link.wr_addr == UGC_CTRL_SFR_ADDR);
    assign clocks_running = controller_enable_ff && !suspend_clock_gate_ff;

    // bus reset: single-ended zero held long enough while the controller is on
    ugc_hold_timer #(
        .CYCLES(SE0_CYCLES)
    ) u_se0_timer (
        .i_core_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_run(I_BUS_SE0 && controller_enable_ff),
        .o_done(se0_long)
    );

    // bus idle counted on the core clock so it keeps going while usb clocks are gated
    ugc_hold_timer #(
        .CYCLES(SUSPEND_CYCLES)
    ) u_suspend_timer (
        .i_core_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_run(I_BUS_IDLE && controller_enable_ff),
        .o_done(suspended_long)
    );

    // one resume per request: rearmed when firmware clears the request or the enable bit
    assign wake_start = remote_wake_request_ff && remote_wake_allowed_ff && clocks_running
        && suspended_long && !upstream_resume_active_ff && !wake_fired_ff;

    always_comb begin
        nxt_controller_enable = controller_enable_ff;
        nxt_suspend_clock_gate = suspend_clock_gate_ff;
        nxt_remote_wake_request = remote_wake_request_ff;
        nxt_detach = detach_ff;
        nxt_remote_wake_allowed = remote_wake_allowed_ff;
        nxt_device_configured_flag = device_configured_flag_ff;
        nxt_function_address_valid = function_address_valid_ff;
        nxt_upstream_resume_active = upstream_resume_active_ff;
        nxt_wake_fired = wake_fired_ff;
        if (reg_write) begin
            // the resume flag is read only and takes nothing from a write
            nxt_controller_enable = link.wr_data[UGC_BIT_CONTROLLER_ENABLE];
            nxt_suspend_clock_gate = link.wr_data[UGC_BIT_SUSPEND_CLOCK_GATE];
            nxt_remote_wake_request = link.wr_data[UGC_BIT_REMOTE_WAKE_REQUEST];
            nxt_detach = link.wr_data[UGC_BIT_DETACH];
            nxt_remote_wake_allowed = link.wr_data[UGC_BIT_REMOTE_WAKE_ALLOWED];
            nxt_device_configured_flag = link.wr_data[UGC_BIT_DEVICE_CONFIGURED_FLAG];
            nxt_function_address_valid = link.wr_data[UGC_BIT_FUNCTION_ADDRESS_VALID];
        end
        if (wake_start) begin
            nxt_upstream_resume_active = 1'b1;
            nxt_wake_fired = 1'b1;
        end else if (I_RESUME_SENT) begin
            nxt_upstream_resume_active = 1'b0;
        end
        if (!remote_wake_request_ff) begin
            nxt_wake_fired = 1'b0;
        end
        // a disabled controller drops any resume in flight and rearms the wake request
        if (!controller_enable_ff) begin
            nxt_upstream_resume_active = 1'b0;
            nxt_wake_fired = 1'b0;
        end
        // bus reset beats a firmware write in the same cycle
        if (se0_long) begin
            nxt_device_configured_flag = 1'b0;
            nxt_function_address_valid = 1'b0;
        end
    end

    always_comb begin
        nxt_clock_run = nxt_controller_enable && !nxt_suspend_clock_gate;
        nxt_vref_oe = !nxt_detach;
        nxt_default_addr = !nxt_function_address_valid;
        nxt_bus_reset = se0_long;
        nxt_ctrl_reg = UGC_CTRL_RESET;
        nxt_ctrl_reg[UGC_BIT_CONTROLLER_ENABLE] = nxt_controller_enable;
        nxt_ctrl_reg[UGC_BIT_SUSPEND_CLOCK_GATE] = nxt_suspend_clock_gate;
        nxt_ctrl_reg[UGC_BIT_REMOTE_WAKE_REQUEST] = nxt_remote_wake_request;
        nxt_ctrl_reg[UGC_BIT_DETACH] = nxt_detach;
        nxt_ctrl_reg[UGC_BIT_UPSTREAM_RESUME_ACTIVE] = nxt_upstream_resume_active;
        nxt_ctrl_reg[UGC_BIT_REMOTE_WAKE_ALLOWED] = nxt_remote_wake_allowed;
        nxt_ctrl_reg[UGC_BIT_DEVICE_CONFIGURED_FLAG] = nxt_device_configured_flag;
        nxt_ctrl_reg[UGC_BIT_FUNCTION_ADDRESS_VALID] = nxt_function_address_valid;
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            controller_enable_ff <= 1'b0;
            suspend_clock_gate_ff <= 1'b0;
            remote_wake_request_ff <= 1'b0;
            detach_ff <= 1'b0;
            upstream_resume_active_ff <= 1'b0;
            remote_wake_allowed_ff <= 1'b0;
            device_configured_flag_ff <= 1'b0;
            function_address_valid_ff <= 1'b0;
            wake_fired_ff <= 1'b0;
            clock_run_ff <= 1'b0;
            vref_oe_ff <= 1'b1;
            vref_out_ff <= 1'b1;
            default_addr_ff <= 1'b1;
            bus_reset_ff <= 1'b0;
            ctrl_reg_ff <= UGC_CTRL_RESET;
        end else begin
            controller_enable_ff <= nxt_controller_enable;
            suspend_clock_gate_ff <= nxt_suspend_clock_gate;
            remote_wake_request_ff <= nxt_remote_wake_request;
            detach_ff <= nxt_detach;
            upstream_resume_active_ff <= nxt_upstream_resume_active;
            remote_wake_allowed_ff <= nxt_remote_wake_allowed;
            device_configured_flag_ff <= nxt_device_configured_flag;
            function_address_valid_ff <= nxt_function_address_valid;
            wake_fired_ff <= nxt_wake_fired;
            clock_run_ff <= nxt_clock_run;
            vref_oe_ff <= nxt_vref_oe;
            vref_out_ff <= 1'b1;
            default_addr_ff <= nxt_default_addr;
            bus_reset_ff <= nxt_bus_reset;
            ctrl_reg_ff <= nxt_ctrl_reg;
        end
    end

    assign link.ctrl_reg = ctrl_reg_ff;
    assign O_CONTROLLER_ENABLE = controller_enable_ff;
    assign O_XCVR_ENABLE = controller_enable_ff;
    assign O_CLOCK_RUN = clock_run_ff;
    assign O_VREF_OUT = vref_out_ff;
    assign O_VREF_OE = vref_oe_ff;
    assign O_RESUME_DRIVE = upstream_resume_active_ff;
    assign O_CONFIGURED = device_configured_flag_ff;
    assign O_DEFAULT_ADDR = default_addr_ff;
    assign O_BUS_RESET = bus_reset_ff;
endmodule

// ### rtl/ugc_controller.sv
`timescale 1ns/100ps
module ugc_controller
    import ugc_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    ugc_link_if.ctl link,
    input wire logic [UGC_AVS_ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST
);
    ugc_bus_state_type state_ff;
    ugc_bus_state_type nxt_state;
    logic wait_ff;
    logic nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic wr_stb_ff;
    logic nxt_wr_stb;
    logic [7:0] wr_data_ff;
    logic [7:0] nxt_wr_data;
    logic request;

    assign request = I_AVS_READ || I_AVS_WRITE;

    // every access is answered one edge after it is seen; unmapped reads give zero
    always_comb begin
        nxt_state = state_ff;
        nxt_wait = 1'b1;
        nxt_rdata = rdata_ff;
        nxt_wr_stb = 1'b0;
        nxt_wr_data = wr_data_ff;
        case (state_ff)
            UGC_BUS_IDLE: begin
                if (request) begin
                    nxt_state = UGC_BUS_ACK;
                    nxt_wait = 1'b0;
                    nxt_rdata = UGC_AVS_READ_ZERO;
                    if (I_AVS_READ && I_AVS_ADDRESS == UGC_AVS_CTRL_OFFSET) begin
                        nxt_rdata[7:0] = link.ctrl_reg;
                    end else if (I_AVS_READ && I_AVS_ADDRESS == UGC_AVS_INFO_OFFSET) begin
                        nxt_rdata[7:0] = UGC_CTRL_SFR_ADDR;
                    end
                    if (I_AVS_WRITE && I_AVS_ADDRESS == UGC_AVS_CTRL_OFFSET
                        && I_AVS_BYTEENABLE[0]) begin
                        nxt_wr_stb = 1'b1;
                        nxt_wr_data = I_AVS_WRITEDATA[7:0];
                    end
                end
            end
            UGC_BUS_ACK: begin
                nxt_state = UGC_BUS_IDLE;
            end
            default: begin
                nxt_state = UGC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            state_ff <= UGC_BUS_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= UGC_AVS_READ_ZERO;
            wr_stb_ff <= 1'b0;
            wr_data_ff <= UGC_CTRL_RESET;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            wr_stb_ff <= nxt_wr_stb;
            wr_data_ff <= nxt_wr_data;
        end
    end

    assign link.wr_stb = wr_stb_ff;
    assign link.wr_addr = UGC_CTRL_SFR_ADDR;
    assign link.wr_data = wr_data_ff;
    assign O_AVS_READDATA = rdata_ff;
    assign O_AVS_WAITREQUEST = wait_ff;
endmodule

// ### testbench/ugc_monitor.sv
`timescale 1ns/100ps
module ugc_monitor
    import ugc_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic wr_stb,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] ctrl_reg
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    wire logic hit = wr_stb && (wr_addr == UGC_CTRL_SFR_ADDR);
    wire logic go = ctrl_reg[7] && !ctrl_reg[6] && ctrl_reg[5] && ctrl_reg[2];

    a_reset_clears_reg: assert property (disable iff (1'b0) I_RST |=> ctrl_reg == 8'h00)
        else $error("control register not cleared by reset");
    a_write_takes_bits: assert property (hit
        |=> ctrl_reg[7:4] == $past(wr_data[7:4]) && ctrl_reg[2] == $past(wr_data[2]))
        else $error("written bits not taken");
    a_upper_bits_hold: assert property (!hit
        |=> ctrl_reg[7:4] == $past(ctrl_reg[7:4]) && ctrl_reg[2] == $past(ctrl_reg[2]))
        else $error("writable bit changed without a write");
    a_wake_req_sticky: assert property (ctrl_reg[5] && !hit |=> ctrl_reg[5])
        else $error("wake request cleared by hardware");
    a_flag_needs_cond: assert property ($rose(ctrl_reg[3]) |-> $past(go))
        else $error("resume flag set without all conditions");
    a_flag_ignores_write: assert property (hit && !ctrl_reg[3] && !go |=> !ctrl_reg[3])
        else $error("resume flag set by a write");
    a_disable_drops_flag: assert property (!ctrl_reg[7] |=> !ctrl_reg[3])
        else $error("resume flag kept while disabled");
    a_disabled_is_still: assert property (!ctrl_reg[7] && !ctrl_reg[3] && !hit
        |=> $stable(ctrl_reg))
        else $error("disabled controller changed its register");
    a_low_bits_unset: assert property (!hit
        |=> (ctrl_reg[1:0] & ~$past(ctrl_reg[1:0])) == 2'h0)
        else $error("configured or address bit set by hardware");

    c_resume_start: cover property ($rose(ctrl_reg[3]));
    c_resume_end: cover property ($fell(ctrl_reg[3]) && ctrl_reg[7]);
    c_bus_reset: cover property ($fell(ctrl_reg[1]) && !$past(hit));
endmodule

// ### testbench/usb_global_control_test.sv
`timescale 1ns/100ps
module usb_global_control_test
    import ugc_pkg::*;
;
    localparam logic [3:0] CA = UGC_AVS_CTRL_OFFSET;
    logic clk, rst, se0, idle, sent, rd, wr, wait_req;
    logic [3:0] addr, be;
    logic [31:0] wdata, rdata;
    logic ctl_en, xcvr_en, clk_run, vref, vref_oe, rsm, cfg, dflt, bus_rst;
    logic [7:0] tbl [3] = '{8'h24, 8'hE4, 8'hA0};
    int n_fail, cmp_count;

    ugc_link_if u_ugc_link_if();
    ugc_device #(.SUSPEND_CYCLES(20), .SE0_CYCLES(4)) u_ugc_device (.I_CORE_CLK(clk),
        .I_RST(rst), .link(u_ugc_link_if.dev), .I_BUS_SE0(se0), .I_BUS_IDLE(idle),
        .I_RESUME_SENT(sent), .O_CONTROLLER_ENABLE(ctl_en), .O_XCVR_ENABLE(xcvr_en),
        .O_CLOCK_RUN(clk_run), .O_VREF_OUT(vref), .O_VREF_OE(vref_oe),
        .O_RESUME_DRIVE(rsm), .O_CONFIGURED(cfg), .O_DEFAULT_ADDR(dflt),
        .O_BUS_RESET(bus_rst));
    ugc_controller u_ugc_controller (.I_CORE_CLK(clk), .I_RST(rst),
        .link(u_ugc_link_if.ctl), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_req));
    ugc_monitor u_ugc_monitor (.I_CORE_CLK(clk), .I_RST(rst),
        .wr_stb(u_ugc_link_if.wr_stb), .wr_addr(u_ugc_link_if.wr_addr),
        .wr_data(u_ugc_link_if.wr_data), .ctrl_reg(u_ugc_link_if.ctrl_reg));

    task automatic tally_and_finish();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_pin(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic avs(input logic w, input logic [3:0] a, input logic [7:0] d,
        input logic [3:0] b, output logic [31:0] q);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= {24'h000000, d};
        be <= b;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wait_req !== 1'b0) begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic [3:0] b);
        logic [31:0] q;
        avs(1'b1, a, d, b, q);
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        avs(1'b0, a, 8'h00, 4'hF, q);
        chk(q, exp);
    endtask

    task automatic wait_rsm(input logic lvl);
        int n;
        n = 0;
        while (rsm !== lvl && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk_pin(rsm, lvl);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        {rst, rd, wr, addr, wdata, be, se0, idle, sent} = {1'b1, 45'h0};
        n_fail = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(CA, 32'h0);
        chk_pin(vref_oe, 1'b1);
        chk_pin(vref, 1'b1);
        chk_pin(cfg, 1'b0);
        chk_pin(dflt, 1'b1);
        chk_pin(ctl_en, 1'b0);
        rd_chk(UGC_AVS_INFO_OFFSET, {24'h0, UGC_CTRL_SFR_ADDR});
        rd_chk(4'h8, 32'h0);
        wr_reg(CA, 8'hFF, 4'hF);
        rd_chk(CA, 32'hF7);
        chk_pin(clk_run, 1'b0);
        chk_pin(vref_oe, 1'b0);
        chk_pin(vref, 1'b1);
        chk_pin(cfg, 1'b1);
        chk_pin(xcvr_en, 1'b1);
        chk_pin(dflt, 1'b0);
        wr_reg(CA, 8'h00, 4'hE);
        wr_reg(4'h8, 8'h00, 4'hF);
        rd_chk(CA, 32'hF7);
        wr_reg(CA, 8'hBF, 4'hF);
        chk_pin(clk_run, 1'b1);
        wr_reg(CA, 8'h83, 4'hF);
        se0 <= 1'b1;
        repeat (2) @(posedge clk);
        se0 <= 1'b0;
        rd_chk(CA, 32'h83);
        se0 <= 1'b1;
        repeat (8) @(posedge clk);
        chk_pin(bus_rst, 1'b1);
        se0 <= 1'b0;
        rd_chk(CA, 32'h80);
        chk_pin(cfg, 1'b0);
        chk_pin(dflt, 1'b1);
        idle <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr_reg(CA, tbl[i], 4'hF);
            repeat (40) @(posedge clk);
            rd_chk(CA, {24'h0, tbl[i]});
        end
        wr_reg(CA, 8'hA4, 4'hF);
        wait_rsm(1'b1);
        rd_chk(CA, 32'hAC);
        sent <= 1'b1;
        @(posedge clk);
        sent <= 1'b0;
        wait_rsm(1'b0);
        repeat (40) @(posedge clk);
        rd_chk(CA, 32'hA4);
        wr_reg(CA, 8'h84, 4'hF);
        wr_reg(CA, 8'hA4, 4'hF);
        wait_rsm(1'b1);
        wr_reg(CA, 8'h00, 4'hF);
        rd_chk(CA, 32'h0);
        chk_pin(ctl_en, 1'b0);
        chk_pin(xcvr_en, 1'b0);
        idle <= 1'b0;
        @(posedge clk);
        idle <= 1'b1;
        wr_reg(CA, 8'hA4, 4'hF);
        repeat (5) @(posedge clk);
        chk_pin(rsm, 1'b0);
        wait_rsm(1'b1);
        tally_and_finish();
    end
endmodule
